// File: hdl/cds_decoder.sv
`timescale 1ns/1ps
module cds_decoder (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               small_variant,
  input  wire logic               acc_valid,
  input  wire logic               acc_write,
  input  wire logic               acc_port,
  input  cds_pkg::cds_mode_t      acc_mode,
  input  cds_pkg::cds_ptr_t       acc_ptr,
  input  wire logic [15:0]        acc_addr,
  input  wire logic [5:0]         acc_disp,
  input  wire logic [7:0]         acc_wdata,
  output logic                    acc_ready,
  output logic                    acc_done,
  output logic [7:0]              acc_rdata,
  output logic [15:0]             acc_eaddr,
  output cds_pkg::cds_region_t    acc_region,
  input  wire logic               alu_we,
  input  wire logic [4:0]         alu_idx,
  input  wire logic [7:0]         alu_wdata,
  input  wire logic [4:0]         alu_rd_idx,
  output logic [7:0]              alu_rd_data,
  output logic                    io_sel,
  output logic                    io_write,
  output logic [7:0]              io_addr,
  output logic [7:0]              io_wdata,
  input  wire logic [7:0]         io_rdata
);
  typedef enum {cds_idle, cds_sram_wait} cds_state_t;

  logic [31:0][7:0]     regs;
  logic [31:0][7:0]     next_regs;
  cds_state_t           state;
  logic                 done;
  logic [7:0]           rdata;
  logic [15:0]          eaddr;
  cds_pkg::cds_region_t region_q;
  logic                 acc_wr_q;

  cds_sram_if sram_bus ();

  // pointer pair base index
  function automatic logic [4:0] ptr_low(input cds_pkg::cds_ptr_t sel);
    unique case (sel)
      cds_pkg::cds_ptr_x: ptr_low = cds_pkg::CDS_PTR_X_LOW;
      cds_pkg::cds_ptr_y: ptr_low = cds_pkg::CDS_PTR_Y_LOW;
      cds_pkg::cds_ptr_z: ptr_low = cds_pkg::CDS_PTR_Z_LOW;
      default:            ptr_low = cds_pkg::CDS_PTR_X_LOW;
    endcase
  endfunction

  // two working registers joined low byte first into one address
  function automatic logic [15:0] ptr_value(input logic [31:0][7:0] r,
                                            input cds_pkg::cds_ptr_t sel);
    logic [4:0] lo;
    lo = ptr_low(sel);
    ptr_value = {r[lo + 5'h01], r[lo]};
  endfunction

  // one linear map shared by every mode; the checks below restate its bounds from the package constants
  function automatic cds_pkg::cds_region_t region_of(input logic [15:0] a,
                                                     input logic is_small);
    logic [15:0] last;
    last = is_small ? cds_pkg::SRAM_LAST_SMALL : cds_pkg::SRAM_LAST_ADDRESS;
    if (a <= cds_pkg::CDS_REG_LAST) begin
      region_of = cds_pkg::cds_reg;
    end else if (a <= cds_pkg::CDS_STDIO_LAST) begin
      region_of = cds_pkg::cds_stdio;
    end else if (a <= cds_pkg::CDS_EXTIO_LAST) begin
      region_of = cds_pkg::cds_extio;
    end else if (a <= last) begin
      region_of = cds_pkg::cds_sram;
    end else begin
      region_of = cds_pkg::cds_none;
    end
  endfunction

  // request acceptance and pointer selection
  wire logic        accept   = acc_valid && acc_ready;
  wire logic [15:0] ptr_val  = ptr_value(regs, acc_ptr);
  wire logic [4:0]  ptr_lo   = ptr_low(acc_ptr);
  // x has no displacement form, so x with a displacement acts as plain indirect
  wire logic        disp_ok  = acc_ptr != cds_pkg::cds_ptr_x;
  wire logic [15:0] disp_ext = {10'h000, acc_disp};
  wire logic [15:0] ptr_dec  = ptr_val - 16'h0001;
  wire logic [15:0] ptr_inc  = ptr_val + 16'h0001;

  // effective address for each mode
  logic [15:0] mem_ea;
  always_comb begin
    unique case (acc_mode)
      cds_pkg::cds_direct:  mem_ea = acc_addr;
      cds_pkg::cds_disp:    mem_ea = disp_ok ? ptr_val + disp_ext : ptr_val;
      cds_pkg::cds_predec:  mem_ea = ptr_dec;
      default:              mem_ea = ptr_val;
    endcase
  end

  // short port instructions carry a 6-bit index into standard i/o only
  wire logic [15:0] port_ea = cds_pkg::CDS_STDIO_BASE + {10'h000, acc_addr[5:0]};
  wire logic [15:0] ea      = acc_port ? port_ea : mem_ea;
  wire cds_pkg::cds_region_t ea_region = region_of(ea, small_variant);

  // pointer write-back for the two auto-update modes
  wire logic ptr_upd = accept && !acc_port &&
                       (acc_mode == cds_pkg::cds_predec ||
                        acc_mode == cds_pkg::cds_postinc);
  wire logic [15:0] ptr_new = (acc_mode == cds_pkg::cds_predec) ? ptr_dec : ptr_inc;

  wire logic is_reg  = ea_region == cds_pkg::cds_reg;
  wire logic is_io   = ea_region == cds_pkg::cds_stdio || ea_region == cds_pkg::cds_extio;
  wire logic is_sram = ea_region == cds_pkg::cds_sram;
  wire logic [7:0] reg_read = regs[ea[4:0]];

  // register file next state; the pointer update is applied last so it wins
  always_comb begin
    next_regs = regs;
    if (alu_we) begin
      next_regs[alu_idx] = alu_wdata;
    end
    if (accept && is_reg && acc_write) begin
      next_regs[ea[4:0]] = acc_wdata;
    end
    if (ptr_upd) begin
      next_regs[ptr_lo]         = ptr_new[7:0];
      next_regs[ptr_lo + 5'h01] = ptr_new[15:8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regs <= '0;
    end else begin
      regs <= next_regs;
    end
  end

  // i/o strobes go out in the accepting cycle; read data is sampled there too
  assign io_sel   = accept && is_io;
  assign io_write = accept && is_io && acc_write;
  assign io_addr  = ea[7:0];
  assign io_wdata = acc_wdata;

  // sram request also issued combinationally so the access fits in two cycles
  wire logic [15:0] sram_off = ea - cds_pkg::SRAM_BASE_ADDRESS;
  assign sram_bus.req   = accept && is_sram;
  assign sram_bus.we    = acc_write;
  assign sram_bus.addr  = sram_off[cds_pkg::CDS_SRAM_AW-1:0];
  assign sram_bus.wdata = acc_wdata;

  cds_sram u_sram (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .port    (sram_bus.mem)
  );

  // read value for the single-cycle regions; unmapped space reads zero
  logic [7:0] fast_rdata;
  always_comb begin
    unique case (ea_region)
      cds_pkg::cds_reg:   fast_rdata = reg_read;
      cds_pkg::cds_stdio: fast_rdata = io_rdata;
      cds_pkg::cds_extio: fast_rdata = io_rdata;
      default:            fast_rdata = 8'h00;
    endcase
  end

  // access sequencer: sram holds the core off for one extra cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= cds_idle;
      done  <= 1'b0;
    end else begin
      unique case (state)
        cds_idle: begin
          done  <= accept && !is_sram;
          state <= (accept && is_sram) ? cds_sram_wait : cds_idle;
        end
        cds_sram_wait: begin
          done  <= 1'b1;
          state <= cds_idle;
        end
      endcase
    end
  end

  // result capture; the write flag is latched so the core may change acc_write
  // during the sram wait without turning a store into a load at completion
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata    <= 8'h00;
      eaddr    <= 16'h0000;
      region_q <= cds_pkg::cds_none;
      acc_wr_q <= 1'b0;
    end else if (accept) begin
      rdata    <= acc_write ? 8'h00 : fast_rdata;
      eaddr    <= ea;
      region_q <= ea_region;
      acc_wr_q <= acc_write;
    end else if (sram_bus.ack && !acc_wr_q) begin
      rdata    <= sram_bus.rdata;
    end
  end

  assign acc_ready   = state == cds_idle;
  assign acc_done    = done;
  assign acc_rdata   = rdata;
  assign acc_eaddr   = eaddr;
  assign acc_region  = region_q;
  assign alu_rd_data = regs[alu_rd_idx];

  // checks
  a_reg_read_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_write && ea <= cds_pkg::CDS_REG_LAST
    |=> acc_done && acc_rdata == $past(reg_read))
    else $error("register-file read returned wrong data");

  // a store into the register window lands unless a pointer update claims the pair
  a_reg_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && acc_write && ea <= cds_pkg::CDS_REG_LAST && !ptr_upd
    |=> regs[$past(ea[4:0])] == $past(acc_wdata))
    else $error("register-file store did not land");

  a_stdio_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && ea >= cds_pkg::CDS_STDIO_BASE && ea <= cds_pkg::CDS_STDIO_LAST
    |-> io_sel && io_addr == ea[7:0] && !sram_bus.req)
    else $error("standard i/o address not routed to i/o");

  a_extio_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_port && ea >= cds_pkg::CDS_EXTIO_BASE
    && ea <= cds_pkg::CDS_EXTIO_LAST |-> io_sel ##1 acc_done)
    else $error("extended i/o address not routed to i/o");

  a_sram_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && ea >= cds_pkg::SRAM_BASE_ADDRESS
    && ea <= (small_variant ? cds_pkg::SRAM_LAST_SMALL : cds_pkg::SRAM_LAST_ADDRESS)
    |-> sram_bus.req && {4'h0, sram_bus.addr} == ea - cds_pkg::SRAM_BASE_ADDRESS)
    else $error("sram address not routed to sram");

  a_beyond_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_write
    && ea > (small_variant ? cds_pkg::SRAM_LAST_SMALL : cds_pkg::SRAM_LAST_ADDRESS)
    |-> !io_sel && !sram_bus.req ##1 acc_done && acc_rdata == 8'h00)
    else $error("unmapped read did not return zero");

  a_beyond_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && acc_write
    && ea > (small_variant ? cds_pkg::SRAM_LAST_SMALL : cds_pkg::SRAM_LAST_ADDRESS)
    |-> !io_sel && !io_write && !sram_bus.req)
    else $error("unmapped store reached a target");

  a_port_std: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && acc_port |-> io_sel && io_addr >= 8'h20 && io_addr <= 8'h5F)
    else $error("port instruction left standard i/o");

  a_direct_ea: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_port && acc_mode == cds_pkg::cds_direct
    |=> acc_eaddr == $past(acc_addr))
    else $error("direct address altered");

  a_disp_add: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_port && acc_mode == cds_pkg::cds_disp && disp_ok
    |=> acc_eaddr == $past(ptr_val) + {10'h000, $past(acc_disp)})
    else $error("displacement address wrong");

  a_z_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && !acc_port && acc_mode == cds_pkg::cds_indirect
    && acc_ptr == cds_pkg::cds_ptr_z
    |=> acc_eaddr == {$past(regs[31]), $past(regs[30])})
    else $error("z pointer not formed from registers 30 and 31");

  a_ptr_postinc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr_upd && acc_mode == cds_pkg::cds_postinc
    |=> acc_eaddr == $past(ptr_val)
    && ptr_value(regs, $past(acc_ptr)) == $past(ptr_val) + 16'h0001)
    else $error("post-increment pointer not updated");

  a_ptr_predec: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr_upd && acc_mode == cds_pkg::cds_predec
    |=> acc_eaddr == $past(ptr_val) - 16'h0001
    && ptr_value(regs, $past(acc_ptr)) == acc_eaddr)
    else $error("pre-decrement pointer not updated");

  a_sram_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && is_sram |=> !acc_ready && !acc_done ##1 acc_ready && acc_done)
    else $error("sram access not two cycles");

  a_sram_rdata: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && is_sram && !acc_write
    |=> ##1 acc_done && acc_rdata == $past(sram_bus.rdata))
    else $error("sram load data not returned on completion");
endmodule

// File: hdl/cds_pkg.sv
package cds_pkg;
  // data-space map, byte addresses
  localparam logic [15:0] CDS_REG_BASE      = 16'h0000;
  localparam logic [15:0] CDS_REG_LAST      = 16'h001F;
  localparam logic [15:0] CDS_STDIO_BASE    = 16'h0020;
  localparam logic [15:0] CDS_STDIO_LAST    = 16'h005F;
  localparam logic [15:0] CDS_EXTIO_BASE    = 16'h0060;
  localparam logic [15:0] CDS_EXTIO_LAST    = 16'h00FF;
  localparam logic [15:0] SRAM_BASE_ADDRESS = 16'h0100;
  localparam logic [15:0] SRAM_LAST_ADDRESS = 16'h0AFF;
  localparam logic [15:0] SRAM_LAST_SMALL   = 16'h05FF;

  // sizes and widths
  localparam int CDS_REG_COUNT  = 32;
  localparam int CDS_SRAM_BYTES = 2560;
  localparam int CDS_SRAM_AW    = 12;
  localparam int CDS_LINEAR_SPAN = 2816;
  localparam int CDS_DISP_MAX   = 63;

  // sram access takes this many cpu cycles from acceptance to done
  localparam int CDS_SRAM_CYCLES = 2;

  // low register index of each pointer pair
  localparam logic [4:0] CDS_PTR_X_LOW = 5'h1A;
  localparam logic [4:0] CDS_PTR_Y_LOW = 5'h1C;
  localparam logic [4:0] CDS_PTR_Z_LOW = 5'h1E;

  typedef enum logic [2:0] {
    cds_direct, cds_indirect, cds_disp, cds_predec, cds_postinc
  } cds_mode_t;

  typedef enum logic [1:0] {cds_ptr_x, cds_ptr_y, cds_ptr_z} cds_ptr_t;

  typedef enum logic [2:0] {
    cds_reg, cds_stdio, cds_extio, cds_sram, cds_none
  } cds_region_t;
endpackage

// File: hdl/cds_sram.sv
`timescale 1ns/1ps
module cds_sram (
  input wire logic sys_clk,
  input wire logic sys_rst,
  cds_sram_if.mem  port
);
  logic [7:0] mem [cds_pkg::CDS_SRAM_BYTES];
  logic       ack;
  logic [7:0] rdata;

  // ack one cycle after the request, so the whole access spans two cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= port.req;
    end
  end

  // read data held until the next read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (port.req && !port.we) begin
      rdata <= mem[port.addr];
    end
  end

  // storage has no reset; software never relies on sram contents at start
  always_ff @(posedge sys_clk) begin
    if (port.req && port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  assign port.ack   = ack;
  assign port.rdata = rdata;

  a_sram_ack_next: assert property (@(posedge sys_clk) disable iff (sys_rst)
    port.req |=> port.ack && !$past(port.ack))
    else $error("sram ack did not follow request by one cycle");
endmodule

// File: hdl/cds_sram_if.sv
`timescale 1ns/1ps
interface cds_sram_if;
  logic                          req;
  logic                          we;
  logic [cds_pkg::CDS_SRAM_AW-1:0] addr;
  logic [7:0]                    wdata;
  logic [7:0]                    rdata;
  logic                          ack;

  modport ctrl (output req, output we, output addr, output wdata,
                input rdata, input ack);
  modport mem  (input req, input we, input addr, input wdata,
                output rdata, output ack);
endinterface

// File: testbench/cds_io_model.sv
`timescale 1ns/1ps
module cds_io_model (
  input  wire logic       sys_clk,
  input  wire logic       io_sel,
  input  wire logic       io_write,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic [7:0]      io_rdata
);
  logic [7:0] io_mem [0:255];

  // known start pattern so the bench can predict every location
  initial begin
    for (int i = 0; i < 256; i++) begin
      io_mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  // peripheral registers latch a write in the accept cycle
  always_ff @(posedge sys_clk) begin
    if (io_sel && io_write) begin
      io_mem[io_addr] <= io_wdata;
    end
  end

  // unselected: inverse of the byte, so stale data never looks valid
  assign io_rdata = io_sel ? io_mem[io_addr] : ~io_mem[io_addr];
endmodule

// File: testbench/cpu_data_space_decoder_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module cpu_data_space_decoder_tb;
  logic                 sys_clk, sys_rst, small_variant;
  logic                 acc_valid, acc_write, acc_port, acc_ready, acc_done;
  cds_pkg::cds_mode_t   acc_mode;
  cds_pkg::cds_ptr_t    acc_ptr;
  cds_pkg::cds_region_t acc_region, r_reg;
  logic [15:0]          acc_addr, acc_eaddr, r_ea;
  logic [5:0]           acc_disp;
  logic [7:0]           acc_wdata, acc_rdata, alu_wdata, alu_rd_data, r_dat;
  logic                 alu_we, io_sel, io_write, r_sel, r_wr;
  logic [4:0]           alu_idx, alu_rd_idx;
  logic [7:0]           io_addr, io_wdata, io_rdata, r_ioa, r_iow;
  int                   fails, total_checks, r_lat;

  cds_decoder i_cds_decoder (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .small_variant(small_variant), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_port(acc_port), .acc_mode(acc_mode), .acc_ptr(acc_ptr), .acc_addr(acc_addr),
    .acc_disp(acc_disp), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_eaddr(acc_eaddr),
    .acc_region(acc_region), .alu_we(alu_we), .alu_idx(alu_idx), .alu_wdata(alu_wdata),
    .alu_rd_idx(alu_rd_idx), .alu_rd_data(alu_rd_data), .io_sel(io_sel),
    .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  cds_io_model i_cds_io_model (.sys_clk(sys_clk), .io_sel(io_sel), .io_write(io_write),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  // free-running cpu clock, 10 ns period
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one full access; request held until taken, latency counted in cycles
  task automatic access(input logic wr, input logic pt, input cds_pkg::cds_mode_t md,
                        input cds_pkg::cds_ptr_t p, input logic [15:0] ad,
                        input logic [5:0] dp, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge sys_clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_port = pt;
    acc_mode = md;
    acc_ptr = p;
    acc_addr = ad;
    acc_disp = dp;
    acc_wdata = wd;
    // let the combinational strobes settle before they are captured
    #1;
    while (acc_ready !== 1'b1) begin
      n++;
      if (n > 8) begin fails++; close_out(); end
      @(negedge sys_clk);
      #1;
    end
    r_sel = io_sel;
    r_wr = io_write;
    r_ioa = io_addr;
    r_iow = io_wdata;
    @(negedge sys_clk);
    acc_valid = 1'b0;
    r_lat = 1;
    while (acc_done !== 1'b1) begin
      if (r_lat >= 4) begin fails++; close_out(); end
      @(negedge sys_clk);
      r_lat++;
    end
    r_dat = acc_rdata;
    r_ea = acc_eaddr;
    r_reg = acc_region;
  endtask

  task automatic ld(input logic [15:0] ad);
    access(1'b0, 1'b0, cds_pkg::cds_direct, cds_pkg::cds_ptr_x, ad, 6'h00, 8'h00);
  endtask
  task automatic st(input logic [15:0] ad, input logic [7:0] wd);
    access(1'b1, 1'b0, cds_pkg::cds_direct, cds_pkg::cds_ptr_x, ad, 6'h00, wd);
  endtask
  task automatic set_reg(input logic [4:0] idx, input logic [7:0] v);
    @(negedge sys_clk);
    alu_we = 1'b1;
    alu_idx = idx;
    alu_wdata = v;
    @(negedge sys_clk);
    alu_we = 1'b0;
  endtask
  task automatic ptr(input logic [4:0] lo, output logic [15:0] v);
    alu_rd_idx = lo;
    #1 v[7:0] = alu_rd_data;
    @(negedge sys_clk);
    alu_rd_idx = lo + 5'h01;
    #1 v[15:8] = alu_rd_data;
  endtask

  task automatic t_map();
    logic [15:0] ads [10] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF,
                              16'h0100, 16'h0AFF, 16'h0B00, 16'h05FF, 16'h0600};
    cds_pkg::cds_region_t rg [10] = '{cds_pkg::cds_reg, cds_pkg::cds_stdio,
      cds_pkg::cds_stdio, cds_pkg::cds_extio, cds_pkg::cds_extio, cds_pkg::cds_sram,
      cds_pkg::cds_sram, cds_pkg::cds_none, cds_pkg::cds_sram, cds_pkg::cds_none};
    for (int i = 0; i < 10; i++) begin
      small_variant = (i >= 8);
      // sram has no reset value, so fill the byte before reading it
      if (rg[i] == cds_pkg::cds_sram) st(ads[i], ~ads[i][7:0]);
      ld(ads[i]);
      if (rg[i] == cds_pkg::cds_sram) `CHK(r_dat, ~ads[i][7:0])
      `CHK(r_reg, rg[i])
      `CHK(r_ea, ads[i])
      `CHK(r_lat, (rg[i] == cds_pkg::cds_sram) ? 2 : 1)
      if (rg[i] == cds_pkg::cds_stdio || rg[i] == cds_pkg::cds_extio) begin
        `CHK({r_sel, r_ioa, r_dat}, {1'b1, ads[i][7:0], ads[i][7:0] ^ 8'h5A})
      end
      if (rg[i] == cds_pkg::cds_none) `CHK(r_dat, 8'h00)
    end
    small_variant = 1'b0;
    $display("test map done");
  endtask

  task automatic t_data();
    logic [15:0] v;
    set_reg(5'h05, 8'hA5);
    ld(16'h0005);
    `CHK(r_dat, 8'hA5)
    st(16'h001F, 8'h3C);
    ptr(5'h1E, v);
    `CHK(v[15:8], 8'h3C)
    st(16'h0AFF, 8'hC3);
    ld(16'h0AFF);
    `CHK({r_dat, 8'(r_lat)}, {8'hC3, 8'h02})
    st(16'h0B00, 8'h5A);
    ld(16'h0B00);
    `CHK(r_dat, 8'h00)
    access(1'b0, 1'b1, cds_pkg::cds_direct, cds_pkg::cds_ptr_x, 16'h00FF, 6'h00, 8'h00);
    `CHK({r_ioa, r_dat, r_reg}, {8'h5F, 8'h05, cds_pkg::cds_stdio})
    access(1'b1, 1'b1, cds_pkg::cds_direct, cds_pkg::cds_ptr_x, 16'h0060, 6'h00, 8'h77);
    `CHK({r_wr, r_ioa, r_iow}, {1'b1, 8'h40, 8'h77})
    ld(16'h0040);
    `CHK(r_dat, 8'h77)
    $display("test data done");
  endtask

  task automatic t_ptr();
    logic [15:0] v;
    set_reg(5'h1A, 8'h00);
    set_reg(5'h1B, 8'h01);
    access(1'b1, 1'b0, cds_pkg::cds_postinc, cds_pkg::cds_ptr_x, 16'h0, 6'h00, 8'h11);
    ptr(5'h1A, v);
    `CHK({r_ea, v}, {16'h0100, 16'h0101})
    access(1'b0, 1'b0, cds_pkg::cds_predec, cds_pkg::cds_ptr_x, 16'h0, 6'h00, 8'h00);
    ptr(5'h1A, v);
    `CHK({r_ea, v, r_dat}, {16'h0100, 16'h0100, 8'h11})
    set_reg(5'h1C, 8'h60);
    set_reg(5'h1D, 8'h00);
    access(1'b0, 1'b0, cds_pkg::cds_predec, cds_pkg::cds_ptr_y, 16'h0, 6'h00, 8'h00);
    ptr(5'h1C, v);
    `CHK({r_ea, v, r_reg}, {16'h005F, 16'h005F, cds_pkg::cds_stdio})
    set_reg(5'h1E, 8'hF0);
    set_reg(5'h1F, 8'h00);
    access(1'b0, 1'b0, cds_pkg::cds_disp, cds_pkg::cds_ptr_z, 16'h0, 6'h3F, 8'h00);
    ptr(5'h1E, v);
    `CHK({r_ea, v, r_reg}, {16'h012F, 16'h00F0, cds_pkg::cds_sram})
    set_reg(5'h03, 8'h33);
    set_reg(5'h1E, 8'h03);
    access(1'b0, 1'b0, cds_pkg::cds_indirect, cds_pkg::cds_ptr_z, 16'h0, 6'h00, 8'h00);
    `CHK({r_ea, r_dat, r_reg}, {16'h0003, 8'h33, cds_pkg::cds_reg})
    $display("test pointer done");
  endtask

  // main sequence: reset, reset-state checks, then each test
  initial begin
    fails = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    small_variant = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_port = 1'b0;
    acc_mode = cds_pkg::cds_direct;
    acc_ptr = cds_pkg::cds_ptr_x;
    acc_addr = 16'h0000;
    acc_disp = 6'h00;
    acc_wdata = 8'h00;
    alu_we = 1'b0;
    alu_idx = 5'h00;
    alu_wdata = 8'h00;
    alu_rd_idx = 5'h1A;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    #1 `CHK({acc_ready, acc_done, acc_rdata, acc_eaddr, alu_rd_data},
            {1'b1, 1'b0, 8'h00, 16'h0000, 8'h00})
    `CHK(acc_region, cds_pkg::cds_none)
    $display("test reset done");
    t_map();
    t_data();
    t_ptr();
    close_out();
  end
endmodule
